// ---- logic/mds_switch.sv ----
// memory data switch: slice latches, input and output selection
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mds_switch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cycle_start,
  input wire logic [1:0] cycle_op,
  input wire logic pe_write_select,
  input wire logic io_write_select,
  input wire logic pe_outer_enable,
  input wire logic pe_inner_enable,
  input wire logic [63:0] pe_input_data,
  input wire logic [63:0] io_input_data,
  input wire logic [63:0] memory_read_data,
  output logic memory_write_strobe,
  output logic [63:0] memory_write_data,
  output logic [7:0] memory_byte_enable,
  output logic [63:0] pe_output_data,
  output logic pe_output_valid,
  output logic [63:0] buffer_io_output_data,
  output logic buffer_out_valid,
  input wire logic buffer_out_ready,
  output logic io_output_valid,
  output logic busy
);
  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic [7:0] half_mask(input logic outer,
                                           input logic inner);
    half_mask = (outer ? mds_pkg::outer_byte_mask : 8'h00) |
                (inner ? mds_pkg::inner_byte_mask : 8'h00);
  endfunction

  function automatic logic [63:0] byte_merge(input logic [63:0] old_w,
                                             input logic [63:0] new_w,
                                             input logic [7:0] m);
    logic [63:0] r;
    r = old_w;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) begin
        r[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    byte_merge = r;
  endfunction

  // ***************************************************
  // software registers
  // ***************************************************
  logic [31:0] ctrl;
  logic [1:0] sink_sel;
  logic sw_outer_en;
  logic sw_inner_en;
  logic apb_wr;
  logic [63:0] slice_latch_register;
  logic [63:0] mem_capture;
  mds_pkg::mds_state_t state;
  mds_pkg::mds_op_t op;

  assign sink_sel = ctrl[mds_pkg::ctrl_sink_lsb +: 2];
  assign sw_outer_en = ctrl[mds_pkg::ctrl_outer_en];
  assign sw_inner_en = ctrl[mds_pkg::ctrl_inner_en];
  assign apb_wr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= mds_pkg::ctrl_reset;
    end else if (apb_wr && paddr == mds_pkg::ctrl_addr) begin
      ctrl <= pwdata;
    end
  end

  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      mds_pkg::ctrl_addr: prdata = ctrl;
      mds_pkg::status_addr: prdata = {29'h0, buffer_out_valid,
                                      state};
      mds_pkg::mem_rd_lo_addr: prdata = mem_capture[31:0];
      mds_pkg::mem_rd_hi_addr: prdata = mem_capture[63:32];
      mds_pkg::latch_lo_addr: prdata = slice_latch_register[31:0];
      mds_pkg::latch_hi_addr: prdata = slice_latch_register[63:32];
      default: pslverr = psel && penable;
    endcase
  end

  // ***************************************************
  // cycle sequencer and strobe timing
  // ***************************************************
  logic [2:0] tick;
  logic latch_strobe;
  logic outer_half_enable_latched;
  logic inner_half_enable_latched;
  logic read_output_enable;
  logic transfer_enable;
  logic do_write;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [63:0] fifo_in_data;
  logic busy_q;

  assign latch_strobe = (state == mds_pkg::mds_st_strobe);
  assign busy = (state != mds_pkg::mds_st_idle);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= mds_pkg::mds_st_idle;
      op <= mds_pkg::mds_op_write;
      tick <= 3'h0;
    end else begin
      unique case (state)
        mds_pkg::mds_st_idle: begin
          tick <= 3'h1;
          if (cycle_start) begin
            op <= mds_pkg::mds_op_t'(cycle_op);
            state <= mds_pkg::mds_st_wait;
          end
        end
        mds_pkg::mds_st_wait: begin
          tick <= tick + 3'h1;
          if (tick >= 3'(mds_pkg::strobe_cycles - 1)) begin
            state <= mds_pkg::mds_st_strobe;
          end
        end
        mds_pkg::mds_st_strobe: begin
          state <= mds_pkg::mds_st_done;
        end
        mds_pkg::mds_st_done: begin
          // wait for buffer room on read/transfer toward buffer
          if (!fifo_in_valid || fifo_in_ready) begin
            state <= mds_pkg::mds_st_idle;
          end
        end
      endcase
    end
  end

  // half enables latched at cycle start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      outer_half_enable_latched <= 1'b0;
      inner_half_enable_latched <= 1'b0;
    end else if (state == mds_pkg::mds_st_idle && cycle_start) begin
      if (pe_write_select) begin
        outer_half_enable_latched <= pe_outer_enable && sw_outer_en;
        inner_half_enable_latched <= pe_inner_enable && sw_inner_en;
      end else begin
        outer_half_enable_latched <= 1'b1;
        inner_half_enable_latched <= 1'b1;
      end
    end
  end

  // ***************************************************
  // slice latches with input select
  // ***************************************************
  logic [63:0] in_sel_data;
  logic [7:0] latch_mask;
  logic src_ok;

  // pe select wins when both raised, none means no latch
  assign src_ok = pe_write_select || io_write_select;
  assign in_sel_data = pe_write_select ? pe_input_data
                                       : io_input_data;
  assign latch_mask = half_mask(outer_half_enable_latched,
                                inner_half_enable_latched);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slice_latch_register <= 64'h0;
    end else if (latch_strobe && src_ok &&
                 op != mds_pkg::mds_op_read) begin
      slice_latch_register <= byte_merge(slice_latch_register,
                                         in_sel_data,
                                         latch_mask);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_capture <= 64'h0;
    end else if (latch_strobe && op == mds_pkg::mds_op_read) begin
      mem_capture <= memory_read_data;
    end
  end

  // ***************************************************
  // destinations and output select
  // ***************************************************
  assign do_write = (state == mds_pkg::mds_st_done) &&
                    op == mds_pkg::mds_op_write && src_ok;
  assign read_output_enable = (state == mds_pkg::mds_st_done) &&
                              op == mds_pkg::mds_op_read;
  assign transfer_enable = (state == mds_pkg::mds_st_done) &&
                           op == mds_pkg::mds_op_transfer;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_write_strobe <= 1'b0;
      memory_write_data <= 64'h0;
      memory_byte_enable <= 8'h00;
      pe_output_data <= 64'h0;
      pe_output_valid <= 1'b0;
      io_output_valid <= 1'b0;
    end else begin
      memory_write_strobe <= do_write && !memory_write_strobe;
      memory_byte_enable <= do_write ? latch_mask : 8'h00;
      if (do_write) begin
        memory_write_data <= slice_latch_register;
      end
      pe_output_valid <= read_output_enable &&
                         sink_sel == mds_pkg::mds_dest_pe && !busy_q;
      if (read_output_enable && sink_sel == mds_pkg::mds_dest_pe) begin
        pe_output_data <= mem_capture;
      end
      io_output_valid <= read_output_enable &&
                         sink_sel == mds_pkg::mds_dest_io && !busy_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state == mds_pkg::mds_st_done);
    end
  end

  // read to buffer or any transfer goes through the buffer fifo
  // held through done until taken, so a full buffer stalls the cycle
  assign fifo_in_valid = transfer_enable ||
                         (read_output_enable &&
                          sink_sel == mds_pkg::mds_dest_buffer);
  // transfer takes only enabled halves, memory not involved
  assign fifo_in_data = transfer_enable ?
                        (slice_latch_register &
                         {{8{latch_mask[7]}}, {8{latch_mask[6]}},
                          {8{latch_mask[5]}}, {8{latch_mask[4]}},
                          {8{latch_mask[3]}}, {8{latch_mask[2]}},
                          {8{latch_mask[1]}}, {8{latch_mask[0]}}})
                        : mem_capture;

  logic [63:0] fifo_out_data;
  logic [63:0] io_hold;
  mds_fifo #(
    .width(mds_pkg::data_width),
    .depth(mds_pkg::fifo_depth)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(buffer_out_valid),
    .out_ready(buffer_out_ready),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_hold <= 64'h0;
    end else if (read_output_enable &&
                 sink_sel == mds_pkg::mds_dest_io) begin
      io_hold <= mem_capture;
    end
  end

  // io side shows buffer head when present, else io read data
  assign buffer_io_output_data = buffer_out_valid ? fifo_out_data
                                                  : io_hold;
endmodule // mds_switch

// ***************************************************
// buffer fifo, valid/ready on both sides
// ***************************************************
module mds_fifo #(
  parameter int unsigned width = 64,
  parameter int unsigned depth = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int unsigned aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr;
  logic [aw-1:0] rd_ptr;
  logic [aw:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != (aw + 1)'(depth));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // mds_fifo
`default_nettype wire

// ---- logic/mds_pkg.sv ----
// package of constants for the memory data switch
package mds_pkg;
  localparam int unsigned data_width = 64;
  localparam int unsigned half_width = 32;
  localparam int unsigned slice_count = 8;
  localparam int unsigned slice_width = 8;
  localparam int unsigned fifo_depth = 16;
  localparam int unsigned clk_period_ns = 25;
  // cycle timing: strobe at 55 ns into cycle, 8 ns wide
  localparam int unsigned strobe_time_ns = 55;
  localparam int unsigned strobe_width_ns = 8;
  localparam int unsigned strobe_cycles =
    (strobe_time_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned strobe_len_cycles =
    (strobe_width_ns / clk_period_ns) < 1 ? 1 :
    (strobe_width_ns / clk_period_ns);
  // register byte addresses
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] mem_rd_lo_addr = 12'h008;
  localparam logic [11:0] mem_rd_hi_addr = 12'h00c;
  localparam logic [11:0] latch_lo_addr = 12'h010;
  localparam logic [11:0] latch_hi_addr = 12'h014;
  // ctrl field positions
  localparam int unsigned ctrl_sink_lsb = 0;
  localparam int unsigned ctrl_outer_en = 2;
  localparam int unsigned ctrl_inner_en = 3;
  localparam logic [31:0] ctrl_reset = 32'h0000_000c;
  // inner half byte mask: bytes 1..4 (bits 8..39)
  localparam logic [7:0] inner_byte_mask = 8'h1e;
  localparam logic [7:0] outer_byte_mask = 8'he1;
  // read destinations
  typedef enum logic [1:0] {
    mds_dest_pe = 2'b00,
    mds_dest_buffer = 2'b01,
    mds_dest_io = 2'b10
  } mds_dest_t;
  // cycle kinds
  typedef enum logic [1:0] {
    mds_op_write = 2'b00,
    mds_op_read = 2'b01,
    mds_op_transfer = 2'b10
  } mds_op_t;
  typedef enum logic [1:0] {
    mds_st_idle = 2'b00,
    mds_st_wait = 2'b01,
    mds_st_strobe = 2'b10,
    mds_st_done = 2'b11
  } mds_state_t;
endpackage

// ---- logic/mds_fifo.sv ----
// empty: the buffer fifo module is defined with the switch logic

// ---- verification/mds_far_end.sv ----
// far-side model: element memory and control buffer sink
`timescale 1ns/1ps
`default_nettype none
module mds_far_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic memory_write_strobe,
  input wire logic [63:0] memory_write_data,
  input wire logic [7:0] memory_byte_enable,
  input wire logic buffer_out_valid,
  input wire logic stall,
  output logic [63:0] memory_read_data,
  output logic buffer_out_ready
);
  // ****
  // memory word and buffer pops
  // ****
  int seed = 2014;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_read_data <= 64'h0;
      buffer_out_ready <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (memory_write_strobe && memory_byte_enable[i]) begin
          memory_read_data[i*8+:8] <= memory_write_data[i*8+:8];
        end
      end
      buffer_out_ready <= !stall && (($random(seed) & 1) != 0);
    end
  end
endmodule // mds_far_end
`default_nettype wire

// ---- verification/mds_props.sv ----
// checker of the switch cycle rules at the top ports
`timescale 1ns/1ps
`default_nettype none
module mds_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cycle_start,
  input wire logic [1:0] cycle_op,
  input wire logic pe_write_select,
  input wire logic io_write_select,
  input wire logic pe_outer_enable,
  input wire logic pe_inner_enable,
  input wire logic memory_write_strobe,
  input wire logic [7:0] memory_byte_enable,
  input wire logic pe_output_valid,
  input wire logic io_output_valid,
  input wire logic busy
);
  // ****
  // cycle assertions
  // ****
  wire logic st = !busy && cycle_start;
  wire logic wr = st && cycle_op == 2'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_BUSY_SPAN: assert property ($rose(busy) |-> busy [*4])
    else $error("cycle ended early");
  AST_WSTB_PULSE: assert property (memory_write_strobe |=>
    !memory_write_strobe) else $error("write strobe too long");
  AST_NO_SELECT: assert property (wr && !pe_write_select &&
    !io_write_select |=> !memory_write_strobe [*7])
    else $error("write without select");
  AST_IO_FULL: assert property (wr && !pe_write_select &&
    io_write_select |-> ##[4:8] memory_write_strobe &&
    memory_byte_enable == 8'hff) else $error("io write not full");
  AST_INNER: assert property (wr && pe_write_select &&
    pe_inner_enable && !pe_outer_enable |-> ##[4:8]
    memory_write_strobe && memory_byte_enable == 8'h1e)
    else $error("inner half wrong");
  AST_OUTER: assert property (wr && pe_write_select &&
    !pe_inner_enable && pe_outer_enable |-> ##[4:8]
    memory_write_strobe && memory_byte_enable == 8'he1)
    else $error("outer half wrong");
  AST_XFER_NOWRITE: assert property (st && cycle_op == 2'h2
    |=> !memory_write_strobe [*7]) else $error("transfer wrote");
  AST_READ_NOWRITE: assert property (st && cycle_op == 2'h1
    |=> !memory_write_strobe [*7]) else $error("read wrote");
  AST_OUT_PULSE: assert property (pe_output_valid ||
    io_output_valid |=> !pe_output_valid && !io_output_valid)
    else $error("output valid too long");
endmodule // mds_props
bind mds_switch mds_props u_props (.pclk, .presetn, .cycle_start,
  .cycle_op, .pe_write_select, .io_write_select, .pe_outer_enable,
  .pe_inner_enable, .memory_write_strobe, .memory_byte_enable,
  .pe_output_valid, .io_output_valid, .busy);
`default_nettype wire

// ---- verification/memory_data_switch_tb.sv ----
// self-checking bench of the memory data switch
`timescale 1ns/1ps
`default_nettype none
module memory_data_switch_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
  logic cycle_start, pe_write_select, io_write_select, busy, er;
  logic pe_outer_enable, pe_inner_enable, memory_write_strobe;
  logic pe_output_valid, buffer_out_valid, buffer_out_ready;
  logic io_output_valid;
  logic [1:0] cycle_op;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] memory_byte_enable, wr_be;
  logic [63:0] pe_input_data, io_input_data, memory_read_data;
  logic [63:0] memory_write_data, pe_output_data, buffer_io_output_data;
  logic [63:0] wr_d, pe_d, ex_latch, ex_mem, q[$];
  int n_fail, n_checks, n_wr, n_pe, n_io, seed = 2014;
  mds_switch DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cycle_start, .cycle_op,
    .pe_write_select, .io_write_select, .pe_outer_enable,
    .pe_inner_enable, .pe_input_data, .io_input_data, .memory_read_data,
    .memory_write_strobe, .memory_write_data, .memory_byte_enable,
    .pe_output_data, .pe_output_valid, .buffer_io_output_data,
    .buffer_out_valid, .buffer_out_ready, .io_output_valid, .busy);
  mds_far_end u_far (.pclk, .presetn, .memory_write_strobe,
    .memory_write_data, .memory_byte_enable, .buffer_out_valid, .stall,
    .memory_read_data, .buffer_out_ready);
  // ****
  // helpers
  // ****
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    n_checks++;
    if (c !== 1'b1) begin
      n_fail++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function logic [63:0] merge(input logic [63:0] o, n, input logic [7:0] m);
    for (int i = 0; i < 8; i++) merge[i*8+:8] = m[i] ? n[i*8+:8] : o[i*8+:8];
  endfunction
  task run(input logic [1:0] op, input logic ps, is, oe, ie,
           input logic [1:0] s, input logic blk);
    logic [63:0] pd, id;
    logic [7:0] m;
    pd = {$random(seed), $random(seed)};
    id = {$random(seed), $random(seed)};
    m = ps ? ((oe ? 8'he1 : 8'h00) | (ie ? 8'h1e : 8'h00)) : 8'hff;
    apb(1'b1, mds_pkg::ctrl_addr, {30'h3, s});
    if (op == 2'h2) ex_latch = merge(ex_latch, pd, m);
    if (op == 2'h2) q.push_back(merge(64'h0, ex_latch, m));
    if (op == 2'h1 && s == 2'h1) q.push_back(ex_mem);
    @(posedge pclk);
    cycle_op <= op;
    pe_write_select <= ps;
    io_write_select <= is;
    pe_outer_enable <= oe;
    pe_inner_enable <= ie;
    pe_input_data <= pd;
    io_input_data <= id;
    cycle_start <= 1'b1;
    n_wr = 0;
    n_pe = 0;
    n_io = 0;
    @(posedge pclk);
    cycle_start <= 1'b0;
    @(posedge pclk);
    if (blk) begin
      repeat (20) @(posedge pclk);
      chk(busy === 1'b1, "full buffer");
      stall <= 1'b0;
    end
    while (busy !== 1'b0) @(posedge pclk);
    repeat (3) @(posedge pclk);
    if (op == 2'h0 && (ps || is)) begin
      ex_latch = merge(ex_latch, ps ? pd : id, m);
      ex_mem = merge(ex_mem, ex_latch, m);
      chk(n_wr == 1 && wr_be === m && wr_d === ex_latch, "write");
    end else chk(n_wr == 0, "stray write");
    if (op == 2'h1) begin
      while (buffer_out_valid !== 1'b0) @(posedge pclk);
      chk(n_pe == (s == 0) && n_io == (s == 2), "sink");
      if (s == 0) chk(pe_d === ex_mem, "pe read");
      if (s == 2) chk(buffer_io_output_data === ex_mem, "io read");
      apb(1'b0, mds_pkg::mem_rd_hi_addr, 32'h0);
      chk(rd === ex_mem[63:32], "read reg");
    end
    apb(1'b0, mds_pkg::latch_lo_addr, 32'h0);
    chk(rd === ex_latch[31:0], "latch lo");
    apb(1'b0, mds_pkg::latch_hi_addr, 32'h0);
    chk(rd === ex_latch[63:32], "latch hi");
  endtask
  always @(posedge pclk) begin
    if (memory_write_strobe === 1'b1) begin
      n_wr++;
      wr_d = memory_write_data;
      wr_be = memory_byte_enable;
    end
    if (pe_output_valid === 1'b1) n_pe++;
    if (pe_output_valid === 1'b1) pe_d = pe_output_data;
    if (io_output_valid === 1'b1) n_io++;
    if (buffer_out_valid === 1'b1 && buffer_out_ready === 1'b1) begin
      chk(buffer_io_output_data === q[0], "buffer word");
      if (q.size() > 0) q.pop_front();
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] r;
    logic [1:0] op, en;
    {psel, penable, pwrite, paddr, pwdata, stall, cycle_start} = '0;
    {cycle_op, pe_write_select, io_write_select} = '0;
    {pe_outer_enable, pe_inner_enable, pe_input_data, io_input_data} = '0;
    {n_fail, n_checks, ex_latch, ex_mem} = '0;
    presetn = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, mds_pkg::ctrl_addr, 32'h0);
    chk(rd === mds_pkg::ctrl_reset, "ctrl reset");
    apb(1'b1, 12'h020, 32'hffff_ffff);
    apb(1'b0, 12'h020, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
    run(2'h0, 1, 1, 1, 1, 0, 0);
    run(2'h0, 1, 0, 0, 1, 0, 0);
    run(2'h0, 1, 0, 1, 0, 0, 0);
    run(2'h0, 0, 1, 0, 0, 0, 0);
    run(2'h0, 0, 0, 1, 1, 0, 0);
    run(2'h2, 1, 0, 0, 1, 0, 0);
    for (int s = 0; s < 3; s++) run(2'h1, 0, 0, 1, 1, s[1:0], 0);
    repeat (40) begin
      r = $random(seed);
      op = r[1:0] % 3;
      en = (r[3:2] == 2'h0) ? 2'h3 : r[3:2];
      run(op, r[4] | (op == 2'h2), r[5], en[1], en[0], r[7:6] % 3, 0);
    end
    while (buffer_out_valid !== 1'b0) @(posedge pclk);
    stall <= 1'b1;
    repeat (16) run(2'h2, 1, 0, 1, 1, 0, 0);
    run(2'h2, 1, 0, 1, 1, 0, 1);
    while (buffer_out_valid !== 1'b0) @(posedge pclk);
    chk(q.size() == 0, "drain");
    report_and_stop();
  end
endmodule // memory_data_switch_tb
`default_nettype wire
